/* design/ofd_map.svh */
// Purpose: field positions, scale shifts and masks for the operand field decoder
// Assumes: 16-bit instruction word, 32-bit registers
// Notes: definitions only
`ifndef OFD_MAP_SVH
`define OFD_MAP_SVH
`define OFD_FLD_N 11:8
`define OFD_FLD_M 7:4
`define OFD_FLD_D4 3:0
`define OFD_FLD_D8 7:0
`define OFD_FLD_D12 11:0
`define OFD_FLD_IMM 7:0
`define OFD_SH_X1 2'h0
`define OFD_SH_X2 2'h1
`define OFD_SH_X4 2'h2
`define OFD_PC_LONG_MASK 32'hFFFF_FFFC
`define OFD_REG_ZERO 4'h0
`define OFD_ONE 32'h0000_0001
`endif

/* design/ofd_pkg.sv */
// Purpose: shared types of the operand field decoder
// Assumes: operation class comes from an upstream opcode classifier
// Notes: size codes equal the log2 of the byte count
package ofd_pkg;
   typedef logic [15:0] ofd_instr_t;
   typedef logic [31:0] ofd_word_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } ofd_size_t;

   typedef enum logic [3:0] {
      AM_NONE = 4'b0000,
      AM_DIRECT = 4'b0001,
      AM_INDIRECT = 4'b0010,
      AM_POSTINC = 4'b0011,
      AM_PREDEC = 4'b0100,
      AM_INDEXED = 4'b0101,
      AM_DISP = 4'b0110,
      AM_GBR_DISP = 4'b0111,
      AM_GBR_INDEXED = 4'b1000,
      AM_PC_REL = 4'b1001,
      AM_PC_DISP = 4'b1010,
      AM_IMM = 4'b1011,
      AM_CTRL = 4'b1100,
      AM_ACCUM = 4'b1101
   } ofd_amode_t;

   typedef enum logic [4:0] {
      OP_NONE = 5'b00000,
      OP_N_DIRECT = 5'b00001,
      OP_N_CTRL = 5'b00010,
      OP_N_PREDEC = 5'b00011,
      OP_M_DIRECT = 5'b00100,
      OP_M_POSTINC = 5'b00101,
      OP_M_JUMP = 5'b00110,
      OP_BRANCH_FAR = 5'b00111,
      OP_NM_DIRECT = 5'b01000,
      OP_NM_IND = 5'b01001,
      OP_NM_PREDEC = 5'b01010,
      OP_NM_POSTINC = 5'b01011,
      OP_NM_INDEXED = 5'b01100,
      OP_MULT_ACCUM = 5'b01101,
      OP_MD_LOAD = 5'b01110,
      OP_ND4_STORE = 5'b01111,
      OP_NMD_STORE = 5'b10000,
      OP_NMD_LOAD = 5'b10001,
      OP_GBR_LOAD = 5'b10010,
      OP_GBR_STORE = 5'b10011,
      OP_MOVE_ADDR = 5'b10100,
      OP_PC_DISP_RN = 5'b10101,
      OP_BR8 = 5'b10110,
      OP_BR12 = 5'b10111,
      OP_IMM_ZX_R0 = 5'b11000,
      OP_IMM_ZX_GBR = 5'b11001,
      OP_IMM_SX_R0 = 5'b11010,
      OP_IMM_SX_RN = 5'b11011,
      OP_TRAP = 5'b11100
   } ofd_op_t;

   typedef struct packed {
      logic [3:0] src_reg;
      ofd_amode_t src_mode;
      logic [3:0] src2_reg;
      ofd_amode_t src2_mode;
      logic [3:0] dst_reg;
      ofd_amode_t dst_mode;
      logic to_accum;
      logic imm_valid;
      ofd_word_t imm;
      logic ea_valid;
      ofd_word_t eaddr;
   } ofd_operands_t;
endpackage

/* design/ofd_ext_scale.sv */
// Purpose: extend a short field to register width and scale it by a left shift
// Assumes: OUT_W larger than IN_W
// Notes: pure combinational
`timescale 1ns/10ps
`default_nettype none
module ofd_ext_scale #(
   parameter int IN_W = 8,
   parameter int OUT_W = 32
) (
   input wire logic [IN_W-1:0] field,
   input wire logic sign_ext,
   input wire logic [1:0] shift,
   output logic [OUT_W-1:0] value
);
   logic [OUT_W-1:0] ext;

   always_comb begin
      ext = {{(OUT_W-IN_W){sign_ext & field[IN_W-1]}}, field};
      value = ext << shift;
   end
endmodule // ofd_ext_scale
`default_nettype wire

/* design/ofd_decoder.sv */
// Purpose: operand field decoder between fetch and execute
// Assumes: register values are read by upstream logic from the nibbles of instr
// Notes: one cycle latency; operands hold between valid inputs
`timescale 1ns/10ps
`default_nettype none
`include "ofd_map.svh"
module ofd_decoder
   import ofd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic in_valid,
   input wire ofd_instr_t instr,
   input wire ofd_op_t in_op,
   input wire ofd_size_t in_size,
   input wire ofd_word_t pc,
   input wire ofd_word_t reg_hi_value,
   input wire ofd_word_t reg_mid_value,
   input wire ofd_word_t reg_zero_value,
   input wire ofd_word_t global_base_reg,
   output logic out_valid,
   output ofd_operands_t operands,
   output logic op_err
);
   ofd_operands_t ops_d, ops_q;
   logic valid_d, valid_q;
   logic err_d, err_q;
   logic [3:0] hi_nib;
   logic [3:0] mid_nib;
   logic [1:0] size_sh;
   logic [1:0] d8_sh;
   logic [1:0] imm_sh;
   logic d8_sign;
   logic imm_sign;
   logic size_bad;
   ofd_word_t d4_val;
   ofd_word_t d8_val;
   ofd_word_t d12_val;
   ofd_word_t imm_val;
   ofd_word_t pc_base;
   ofd_word_t dec_step;

   // the nibbles are named by position only; meaning comes from in_op
   assign hi_nib = instr[`OFD_FLD_N];
   assign mid_nib = instr[`OFD_FLD_M];
   // size codes equal the scale shift, so the size doubles as the shift
   assign size_sh = 2'(in_size);
   assign size_bad = (in_size != SZ_BYTE) && (in_size != SZ_WORD) && (in_size != SZ_LONG);
   assign d8_sign = (in_op == OP_BR8);
   assign d8_sh = (in_op == OP_BR8) ? `OFD_SH_X2 : size_sh;
   assign imm_sign = (in_op == OP_IMM_SX_R0) || (in_op == OP_IMM_SX_RN);
   assign imm_sh = (in_op == OP_TRAP) ? `OFD_SH_X4 : `OFD_SH_X1;
   // longword pc-relative loads see a longword-aligned pc
   assign pc_base = (in_size == SZ_LONG) ? (pc & `OFD_PC_LONG_MASK) : pc;
   assign dec_step = `OFD_ONE << size_sh;

   ofd_ext_scale #(.IN_W(4), .OUT_W(32)) u_disp4 (
      .field(instr[`OFD_FLD_D4]),
      .sign_ext(1'b0),
      .shift(size_sh),
      .value(d4_val)
   );

   ofd_ext_scale #(.IN_W(8), .OUT_W(32)) u_disp8 (
      .field(instr[`OFD_FLD_D8]),
      .sign_ext(d8_sign),
      .shift(d8_sh),
      .value(d8_val)
   );

   ofd_ext_scale #(.IN_W(12), .OUT_W(32)) u_disp12 (
      .field(instr[`OFD_FLD_D12]),
      .sign_ext(1'b1),
      .shift(`OFD_SH_X2),
      .value(d12_val)
   );

   ofd_ext_scale #(.IN_W(8), .OUT_W(32)) u_imm8 (
      .field(instr[`OFD_FLD_IMM]),
      .sign_ext(imm_sign),
      .shift(imm_sh),
      .value(imm_val)
   );

   always_comb begin
      ops_d = '0;
      err_d = size_bad;
      valid_d = in_valid;
      unique case (in_op)
         OP_NONE: begin
         end
         OP_N_DIRECT: begin
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_DIRECT;
         end
         OP_N_CTRL: begin
            ops_d.src_mode = AM_CTRL;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_DIRECT;
         end
         OP_N_PREDEC: begin
            ops_d.src_mode = AM_CTRL;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_PREDEC;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_hi_value - dec_step;
         end
         OP_M_DIRECT: begin
            ops_d.src_reg = hi_nib;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_mode = AM_CTRL;
         end
         OP_M_POSTINC: begin
            ops_d.src_reg = hi_nib;
            ops_d.src_mode = AM_POSTINC;
            ops_d.dst_mode = AM_CTRL;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_hi_value;
         end
         OP_M_JUMP: begin
            ops_d.src_reg = hi_nib;
            ops_d.src_mode = AM_INDIRECT;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_hi_value;
         end
         OP_BRANCH_FAR: begin
            ops_d.src_reg = hi_nib;
            ops_d.src_mode = AM_PC_REL;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = pc + reg_hi_value;
         end
         OP_NM_DIRECT: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_DIRECT;
         end
         OP_NM_IND: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_INDIRECT;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_hi_value;
         end
         OP_NM_PREDEC: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_PREDEC;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_hi_value - dec_step;
         end
         OP_NM_POSTINC: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_POSTINC;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_DIRECT;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_mid_value;
         end
         OP_NM_INDEXED: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_INDEXED;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_hi_value + reg_zero_value;
         end
         OP_MULT_ACCUM: begin
            // both nibbles are sources here; the upper one is not a destination
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_POSTINC;
            ops_d.src2_reg = hi_nib;
            ops_d.src2_mode = AM_POSTINC;
            ops_d.dst_mode = AM_ACCUM;
            ops_d.to_accum = 1'b1;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_mid_value;
         end
         OP_MD_LOAD: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_DISP;
            ops_d.dst_reg = `OFD_REG_ZERO;
            ops_d.dst_mode = AM_DIRECT;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_mid_value + d4_val;
         end
         OP_ND4_STORE: begin
            ops_d.src_reg = `OFD_REG_ZERO;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_reg = mid_nib;
            ops_d.dst_mode = AM_DISP;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_mid_value + d4_val;
         end
         OP_NMD_STORE: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_DISP;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_hi_value + d4_val;
         end
         OP_NMD_LOAD: begin
            ops_d.src_reg = mid_nib;
            ops_d.src_mode = AM_DISP;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_DIRECT;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = reg_mid_value + d4_val;
         end
         OP_GBR_LOAD: begin
            ops_d.src_mode = AM_GBR_DISP;
            ops_d.dst_reg = `OFD_REG_ZERO;
            ops_d.dst_mode = AM_DIRECT;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = global_base_reg + d8_val;
         end
         OP_GBR_STORE: begin
            ops_d.src_reg = `OFD_REG_ZERO;
            ops_d.src_mode = AM_DIRECT;
            ops_d.dst_mode = AM_GBR_DISP;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = global_base_reg + d8_val;
         end
         OP_MOVE_ADDR, OP_PC_DISP_RN: begin
            // byte size has no pc-relative displacement form
            err_d = size_bad || (in_size == SZ_BYTE);
            ops_d.src_mode = AM_PC_DISP;
            ops_d.dst_reg = (in_op == OP_PC_DISP_RN) ? hi_nib : `OFD_REG_ZERO;
            ops_d.dst_mode = AM_DIRECT;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = pc_base + d8_val;
         end
         OP_BR8: begin
            ops_d.src_mode = AM_PC_REL;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = pc + d8_val;
         end
         OP_BR12: begin
            ops_d.src_mode = AM_PC_REL;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = pc + d12_val;
         end
         OP_IMM_ZX_R0, OP_IMM_SX_R0: begin
            ops_d.src_mode = AM_IMM;
            ops_d.imm_valid = 1'b1;
            ops_d.imm = imm_val;
            ops_d.dst_reg = `OFD_REG_ZERO;
            ops_d.dst_mode = AM_DIRECT;
         end
         OP_IMM_ZX_GBR: begin
            ops_d.src_mode = AM_IMM;
            ops_d.imm_valid = 1'b1;
            ops_d.imm = imm_val;
            ops_d.dst_mode = AM_GBR_INDEXED;
            ops_d.ea_valid = 1'b1;
            ops_d.eaddr = global_base_reg + reg_zero_value;
         end
         OP_IMM_SX_RN: begin
            ops_d.src_mode = AM_IMM;
            ops_d.imm_valid = 1'b1;
            ops_d.imm = imm_val;
            ops_d.dst_reg = hi_nib;
            ops_d.dst_mode = AM_DIRECT;
         end
         OP_TRAP: begin
            ops_d.src_mode = AM_IMM;
            ops_d.imm_valid = 1'b1;
            ops_d.imm = imm_val;
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
      // results hold between accepted words so execute may sample late
      if (!in_valid) begin
         ops_d = ops_q;
         err_d = err_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ops_q <= '0;
         valid_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ops_q <= ops_d;
         valid_q <= valid_d;
         err_q <= err_d;
      end
   end

   assign operands = ops_q;
   assign out_valid = valid_q;
   assign op_err = err_q;

   a_pc_reg_sum: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_BRANCH_FAR |=>
         operands.ea_valid && operands.eaddr == $past(pc) + $past(reg_hi_value))
      else $error("pc plus register address wrong");

   a_imm_zero_ext: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_IMM_ZX_R0 |=>
         operands.imm == {24'h00_0000, $past(instr[`OFD_FLD_IMM])})
      else $error("logic immediate not zero extended");

   a_imm_sign_ext: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_IMM_SX_RN |=>
         operands.imm == {{24{$past(instr[7])}}, $past(instr[`OFD_FLD_IMM])}
         && operands.dst_reg == $past(instr[`OFD_FLD_N]))
      else $error("immediate not sign extended");

   a_trap_scale: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_TRAP |=>
         operands.imm == {22'h0, $past(instr[`OFD_FLD_IMM]), 2'h0})
      else $error("trap offset not times four");

   a_idle_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !in_valid |=> !out_valid && $stable(operands))
      else $error("operands changed without a valid word");

   a_single_dest: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_N_PREDEC |=>
         operands.dst_mode == AM_PREDEC && operands.dst_reg == $past(instr[`OFD_FLD_N]))
      else $error("single destination field wrong");

   a_mac_accum: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_MULT_ACCUM |=>
         operands.to_accum && operands.src2_mode == AM_POSTINC && operands.dst_mode == AM_ACCUM)
      else $error("multiply accumulate operands wrong");

   a_disp4_word: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_NMD_LOAD && in_size == SZ_WORD |=>
         operands.eaddr == $past(reg_mid_value) + {27'h0, $past(instr[`OFD_FLD_D4]), 1'b0})
      else $error("four bit displacement wrong");

   a_gbr_long: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_GBR_LOAD && in_size == SZ_LONG |=>
         operands.eaddr == $past(global_base_reg) + {22'h0, $past(instr[`OFD_FLD_D8]), 2'h0})
      else $error("global base displacement wrong");

   a_pc_long_mask: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_MOVE_ADDR && in_size == SZ_LONG |=>
         operands.eaddr[1:0] == 2'h0)
      else $error("longword pc address not aligned");

   a_branch_twelve: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      in_valid && in_op == OP_BR12 |=>
         operands.eaddr == $past(pc) + {{19{$past(instr[11])}}, $past(instr[`OFD_FLD_D12]), 1'b0})
      else $error("branch target wrong");
endmodule // ofd_decoder
`default_nettype wire

/* verification/ofd_decoder_tb.sv */
// Purpose: self-checking bench for the operand field decoder
// Assumes: one cycle latency, operands hold between accepted words
// Notes: expected values are worked out here from the field rules
`timescale 1ns/10ps
`default_nettype none
module testbench
   import ofd_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic in_valid = 1'b0;
   ofd_instr_t instr = 16'h0000;
   ofd_op_t in_op = OP_NONE;
   ofd_size_t in_size = SZ_LONG;
   ofd_word_t pc = 32'h0000_0000;
   ofd_word_t reg_hi_value = 32'h0000_0000;
   ofd_word_t reg_mid_value = 32'h0000_0000;
   ofd_word_t reg_zero_value = 32'h0000_0040;
   ofd_word_t global_base_reg = 32'h0000_8000;
   logic out_valid;
   ofd_operands_t operands;
   logic op_err;
   int mismatches = 0;
   int checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   ofd_decoder DUT (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(in_valid),
      .instr(instr),
      .in_op(in_op),
      .in_size(in_size),
      .pc(pc),
      .reg_hi_value(reg_hi_value),
      .reg_mid_value(reg_mid_value),
      .reg_zero_value(reg_zero_value),
      .global_base_reg(global_base_reg),
      .out_valid(out_valid),
      .operands(operands),
      .op_err(op_err)
   );

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one word in, result looked at just after the edge that answers it
   task automatic send(input ofd_op_t op, input ofd_instr_t ins, input ofd_size_t sz,
                       input ofd_word_t p, input ofd_word_t hi, input ofd_word_t mid);
      @(posedge clk_sys);
      in_valid <= 1'b1;
      in_op <= op;
      instr <= ins;
      in_size <= sz;
      pc <= p;
      reg_hi_value <= hi;
      reg_mid_value <= mid;
      @(posedge clk_sys);
      in_valid <= 1'b0;
      #1;
      chk("out_valid", 32'h1, {31'h0, out_valid});
   endtask

   task automatic t_pc_reg();
      send(OP_BRANCH_FAR, 16'h0523, SZ_LONG, 32'h0000_1000, 32'h0000_0020, 32'h0);
      chk("eaddr", 32'h0000_1020, operands.eaddr);
      chk("ea_valid", 32'h1, {31'h0, operands.ea_valid});
      chk("src_reg", 32'h5, {28'h0, operands.src_reg});
      chk("src_mode", {28'h0, AM_PC_REL}, {28'h0, operands.src_mode});
      $display("test pc_reg done");
   endtask

   task automatic t_imm();
      // register-destination form goes last so its dst_reg still stands after the loop
      ofd_op_t ops[4] = '{OP_IMM_ZX_R0, OP_IMM_SX_R0, OP_TRAP, OP_IMM_SX_RN};
      ofd_word_t exp[4] = '{32'h0000_00FF, 32'hFFFF_FFFF, 32'h0000_03FC, 32'hFFFF_FFFF};
      for (int i = 0; i < 4; i++) begin
         send(ops[i], 16'h7AFF, SZ_LONG, 32'h0000_1000, 32'h0, 32'h0);
         chk("imm", exp[i], operands.imm);
         chk("imm_valid", 32'h1, {31'h0, operands.imm_valid});
      end
      chk("dst_reg", 32'hA, {28'h0, operands.dst_reg});
      send(OP_IMM_ZX_GBR, 16'hCD80, SZ_BYTE, 32'h0, 32'h0, 32'h0);
      chk("imm", 32'h0000_0080, operands.imm);
      chk("eaddr", 32'h0000_8040, operands.eaddr);
      $display("test imm done");
   endtask

   // largest nibble displacement at every size shows both extension and scaling
   task automatic t_disp4();
      for (int s = 0; s < 3; s++) begin
         send(OP_MD_LOAD, 16'h853F, ofd_size_t'(s), 32'h0, 32'h0000_0200, 32'h0000_0100);
         chk("eaddr", 32'h0000_0100 + (32'hF << s), operands.eaddr);
      end
      send(OP_NMD_STORE, 16'h1A3F, SZ_LONG, 32'h0, 32'h0000_0200, 32'h0000_0100);
      chk("eaddr", 32'h0000_023C, operands.eaddr);
      send(OP_NMD_LOAD, 16'h853F, SZ_WORD, 32'h0, 32'h0000_0200, 32'h0000_0100);
      chk("eaddr", 32'h0000_011E, operands.eaddr);
      chk("dst_reg", 32'h5, {28'h0, operands.dst_reg});
      $display("test disp4 done");
   endtask

   task automatic t_gbr();
      for (int s = 0; s < 3; s++) begin
         send(OP_GBR_LOAD, 16'hC6FF, ofd_size_t'(s), 32'h0, 32'h0, 32'h0);
         chk("eaddr", 32'h0000_8000 + (32'hFF << s), operands.eaddr);
      end
      $display("test gbr done");
   endtask

   task automatic t_pc_disp();
      send(OP_MOVE_ADDR, 16'hC701, SZ_LONG, 32'h0000_1003, 32'h0, 32'h0);
      chk("eaddr", 32'h0000_1004, operands.eaddr);
      send(OP_PC_DISP_RN, 16'h9B01, SZ_WORD, 32'h0000_1003, 32'h0, 32'h0);
      chk("eaddr", 32'h0000_1005, operands.eaddr);
      chk("dst_reg", 32'hB, {28'h0, operands.dst_reg});
      send(OP_PC_DISP_RN, 16'h9B01, SZ_BYTE, 32'h0000_1003, 32'h0, 32'h0);
      chk("op_err", 32'h1, {31'h0, op_err});
      send(OP_GBR_LOAD, 16'hC601, ofd_size_t'(2'h3), 32'h0, 32'h0, 32'h0);
      chk("op_err", 32'h1, {31'h0, op_err});
      $display("test pc_disp done");
   endtask

   task automatic t_branch();
      send(OP_BR8, 16'h8980, SZ_LONG, 32'h0000_1000, 32'h0, 32'h0);
      chk("eaddr", 32'h0000_0F00, operands.eaddr);
      send(OP_BR12, 16'hA800, SZ_LONG, 32'h0000_1000, 32'h0, 32'h0);
      chk("eaddr", 32'h0000_0000, operands.eaddr);
      send(OP_BR12, 16'h0FFF, SZ_LONG, 32'd100, 32'h0, 32'h0);
      chk("eaddr", 32'd98, operands.eaddr);
      // operands must hold once the answering cycle is over
      @(posedge clk_sys);
      #1;
      chk("out_valid", 32'h0, {31'h0, out_valid});
      chk("eaddr", 32'd98, operands.eaddr);
      $display("test branch done");
   endtask

   task automatic t_regs();
      send(OP_N_PREDEC, 16'h4D03, SZ_LONG, 32'h0, 32'h0000_0100, 32'h0);
      chk("dst_reg", 32'hD, {28'h0, operands.dst_reg});
      chk("dst_mode", {28'h0, AM_PREDEC}, {28'h0, operands.dst_mode});
      chk("eaddr", 32'h0000_00FC, operands.eaddr);
      send(OP_NM_INDEXED, 16'h0E56, SZ_LONG, 32'h0, 32'h0000_0300, 32'h0);
      chk("dst_reg", 32'hE, {28'h0, operands.dst_reg});
      chk("src_reg", 32'h5, {28'h0, operands.src_reg});
      chk("dst_mode", {28'h0, AM_INDEXED}, {28'h0, operands.dst_mode});
      chk("eaddr", 32'h0000_0340, operands.eaddr);
      $display("test regs done");
   endtask

   task automatic t_mac();
      send(OP_MULT_ACCUM, 16'h4C6F, SZ_WORD, 32'h0, 32'h0000_0500, 32'h0000_0600);
      chk("src_reg", 32'h6, {28'h0, operands.src_reg});
      chk("src2_reg", 32'hC, {28'h0, operands.src2_reg});
      chk("src2_mode", {28'h0, AM_POSTINC}, {28'h0, operands.src2_mode});
      chk("dst_mode", {28'h0, AM_ACCUM}, {28'h0, operands.dst_mode});
      chk("to_accum", 32'h1, {31'h0, operands.to_accum});
      chk("eaddr", 32'h0000_0600, operands.eaddr);
      $display("test mac done");
   endtask

   // remaining single and two-register classes, one word each
   task automatic t_fields();
      send(OP_N_DIRECT, 16'h0329, SZ_LONG, 32'h0, 32'h0, 32'h0);
      chk("dst_reg", 32'h3, {28'h0, operands.dst_reg});
      chk("dst_mode", {28'h0, AM_DIRECT}, {28'h0, operands.dst_mode});
      send(OP_N_CTRL, 16'h072A, SZ_LONG, 32'h0, 32'h0, 32'h0);
      chk("src_mode", {28'h0, AM_CTRL}, {28'h0, operands.src_mode});
      chk("dst_reg", 32'h7, {28'h0, operands.dst_reg});
      send(OP_M_DIRECT, 16'h4A0E, SZ_LONG, 32'h0, 32'h0, 32'h0);
      chk("src_reg", 32'hA, {28'h0, operands.src_reg});
      chk("dst_mode", {28'h0, AM_CTRL}, {28'h0, operands.dst_mode});
      send(OP_M_POSTINC, 16'h4B07, SZ_LONG, 32'h0, 32'h0000_0700, 32'h0);
      chk("src_mode", {28'h0, AM_POSTINC}, {28'h0, operands.src_mode});
      chk("eaddr", 32'h0000_0700, operands.eaddr);
      send(OP_M_JUMP, 16'h492B, SZ_LONG, 32'h0, 32'h0000_2000, 32'h0);
      chk("src_mode", {28'h0, AM_INDIRECT}, {28'h0, operands.src_mode});
      chk("eaddr", 32'h0000_2000, operands.eaddr);
      send(OP_NM_DIRECT, 16'h3A5C, SZ_LONG, 32'h0, 32'h0, 32'h0);
      chk("src_reg", 32'h5, {28'h0, operands.src_reg});
      chk("dst_reg", 32'hA, {28'h0, operands.dst_reg});
      send(OP_NM_IND, 16'h2312, SZ_LONG, 32'h0, 32'h0000_0300, 32'h0);
      chk("dst_mode", {28'h0, AM_INDIRECT}, {28'h0, operands.dst_mode});
      chk("eaddr", 32'h0000_0300, operands.eaddr);
      send(OP_NM_PREDEC, 16'h2634, SZ_BYTE, 32'h0, 32'h0000_0100, 32'h0);
      chk("eaddr", 32'h0000_00FF, operands.eaddr);
      send(OP_NM_POSTINC, 16'h6356, SZ_LONG, 32'h0, 32'h0000_0100, 32'h0000_0500);
      chk("src_mode", {28'h0, AM_POSTINC}, {28'h0, operands.src_mode});
      chk("eaddr", 32'h0000_0500, operands.eaddr);
      send(OP_ND4_STORE, 16'h8139, SZ_WORD, 32'h0, 32'h0, 32'h0000_0400);
      chk("dst_reg", 32'h3, {28'h0, operands.dst_reg});
      chk("eaddr", 32'h0000_0412, operands.eaddr);
      $display("test fields done");
   endtask

   // an unknown class, then the same word under two classes in two words back to back
   task automatic t_opclass();
      send(ofd_op_t'(5'h1F), 16'h8902, SZ_LONG, 32'h0000_1000, 32'h0, 32'h0);
      chk("op_err", 32'h1, {31'h0, op_err});
      chk("eaddr", 32'h0, operands.eaddr);
      @(posedge clk_sys);
      in_valid <= 1'b1;
      in_op <= OP_BR8;
      instr <= 16'h8902;
      @(posedge clk_sys);
      in_op <= OP_TRAP;
      #1;
      chk("eaddr", 32'h0000_1004, operands.eaddr);
      chk("op_err", 32'h0, {31'h0, op_err});
      @(posedge clk_sys);
      in_valid <= 1'b0;
      #1;
      chk("out_valid", 32'h1, {31'h0, out_valid});
      chk("imm", 32'h0000_0008, operands.imm);
      $display("test opclass done");
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      chk("out_valid", 32'h0, {31'h0, out_valid});
      chk("op_err", 32'h0, {31'h0, op_err});
      @(posedge clk_sys);
      rst_b <= 1'b1;
      t_pc_reg();
      t_imm();
      t_disp4();
      t_gbr();
      t_pc_disp();
      t_branch();
      t_regs();
      t_mac();
      t_fields();
      t_opclass();
      end_sim();
   end

   // the whole run is some ninety cycles, so this leaves a wide margin
   initial begin
      #20000;
      mismatches++;
      $display("Error watchdog expected done seen timeout");
      end_sim();
   end
endmodule // testbench
`default_nettype wire
